// [logic/sarcs_pkg.sv]
// Shared constants for the successive-approximation conversion sequencer
package sarcs_pkg;
  localparam int RES_BITS = 12;
  // Internal converter clock: one pulse half, high or low
  localparam int CLK_PERIOD_NS = 8;
  localparam int INT_HALF_NS = 960;
  localparam int INT_HALF_CYC = (INT_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : INT_HALF_NS / CLK_PERIOD_NS;
  // Short-cycle resolution select codes
  localparam logic [1:0] RES_SEL_12 = 2'h0;
  localparam logic [1:0] RES_SEL_10 = 2'h1;
  localparam logic [1:0] RES_SEL_8 = 2'h2;
  localparam logic [3:0] RES_LIM_12 = 4'hC;
  localparam logic [3:0] RES_LIM_10 = 4'hA;
  localparam logic [3:0] RES_LIM_8 = 4'h8;
  // Reset and idle values
  localparam logic SER_IDLE = 1'b1;
  localparam logic [RES_BITS-1:0] PAR_RESET = 12'hFFF;
  localparam logic MSB_INV_RESET = 1'b0;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam int SYNC_STAGES = 2;
  typedef enum logic {
    SARCS_IDLE = 1'b0,
    SARCS_CONV = 1'b1
  } sarcs_state_t;
endpackage

// [logic/sarcs_sync.sv]
// Two-stage synchroniser for a group of asynchronous pin inputs
module sarcs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d_async,
  output logic [WIDTH-1:0] q_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_async;
      sync_reg <= meta_reg;
    end
  end

  assign q_sync = sync_reg;
endmodule

// [logic/sarcs_sequencer.sv]
// Successive-approximation conversion sequencer with parallel and serial result outputs
module sarcs_sequencer #(
  parameter int RES_BITS = sarcs_pkg::RES_BITS,
  parameter int HALF_CYC = sarcs_pkg::INT_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic convert_pin,
  input wire logic ext_clk_pin,
  input wire logic ext_clk_sel_pin,
  input wire logic comp_pin,
  input wire logic [1:0] res_sel_pin,
  output logic busy,
  output logic [RES_BITS-1:0] par_data_n,
  output logic msb_inv,
  output logic ser_data,
  output logic ser_clk,
  output logic [RES_BITS-1:0] dac_trial
);
  localparam int PH_W = $clog2(2 * HALF_CYC + 1);
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(HALF_CYC);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(2 * HALF_CYC - 1);
  localparam logic [RES_BITS-1:0] MSB_ONLY = {1'b1, {(RES_BITS-1){1'b0}}};

  // Pin synchronisation
  logic [5:0] pins_s;
  logic conv_s;
  logic ext_s;
  logic ext_sel_s;
  logic comp_s;
  logic [1:0] res_sel_s;

  sarcs_sync #(.WIDTH(6)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d_async({convert_pin, ext_clk_pin, ext_clk_sel_pin, comp_pin, res_sel_pin}),
    .q_sync(pins_s)
  );

  assign conv_s = pins_s[5];
  assign ext_s = pins_s[4];
  assign ext_sel_s = pins_s[3];
  assign comp_s = pins_s[2];
  assign res_sel_s = pins_s[1:0];

  // State
  sarcs_pkg::sarcs_state_t state_reg, state_next;
  logic conv_d_reg, conv_d_next;
  logic ext_mode_reg, ext_mode_next;
  logic ext_arm_reg, ext_arm_next;
  logic [PH_W-1:0] phase_reg, phase_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [3:0] res_lim_reg, res_lim_next;
  logic [RES_BITS-1:0] trial_reg, trial_next;
  logic [RES_BITS-1:0] par_reg, par_next;
  logic msb_inv_reg, msb_inv_next;
  logic ser_reg, ser_next;
  logic sclk_reg, sclk_next;
  logic busy_reg, busy_next;

  logic conv_rise;
  logic pulse_rise;
  logic pulse_fall;
  logic [3:0] cnt_inc;
  logic [3:0] bit_idx;
  logic [3:0] res_dec;

  assign conv_rise = conv_s & ~conv_d_reg;
  assign cnt_inc = cnt_reg + 4'h1;
  // Bit number n = cnt_inc - 1 lands at vector index RES_BITS - n
  assign bit_idx = 4'(RES_BITS + 1) - cnt_inc;

  always_comb begin
    unique case (res_sel_s)
      sarcs_pkg::RES_SEL_10: res_dec = sarcs_pkg::RES_LIM_10;
      sarcs_pkg::RES_SEL_8: res_dec = sarcs_pkg::RES_LIM_8;
      default: res_dec = sarcs_pkg::RES_LIM_12;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    conv_d_next = conv_s;
    ext_mode_next = ext_mode_reg;
    ext_arm_next = ext_arm_reg;
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    res_lim_next = res_lim_reg;
    trial_next = trial_reg;
    par_next = par_reg;
    msb_inv_next = msb_inv_reg;
    ser_next = ser_reg;
    busy_next = busy_reg;
    sclk_next = 1'b0;
    pulse_rise = 1'b0;
    pulse_fall = 1'b0;
    unique case (state_reg)
      sarcs_pkg::SARCS_IDLE: begin
        ser_next = sarcs_pkg::SER_IDLE;
        if (conv_rise) begin
          state_next = sarcs_pkg::SARCS_CONV;
          busy_next = 1'b1;
          ext_mode_next = ext_sel_s;
          ext_arm_next = 1'b0;
          phase_next = '0;
          cnt_next = sarcs_pkg::CNT_RESET;
          res_lim_next = res_dec;
          trial_next = MSB_ONLY;
        end
      end
      sarcs_pkg::SARCS_CONV: begin
        // Convert edges are not looked at here
        if (ext_mode_reg) begin
          // A clock already high at start is not counted as a pulse
          if (!ext_s) begin
            ext_arm_next = 1'b1;
          end
          sclk_next = ext_s & ext_arm_reg;
        end else begin
          phase_next = (phase_reg == PH_LAST) ? '0 : phase_reg + PH_W'(1);
          sclk_next = (phase_reg < PH_HALF);
        end
        pulse_rise = sclk_next & ~sclk_reg;
        pulse_fall = ~sclk_next & sclk_reg;
        if (pulse_rise) begin
          cnt_next = cnt_inc;
          if (cnt_reg != sarcs_pkg::CNT_RESET) begin
            trial_next[bit_idx] = comp_s;
            ser_next = ~comp_s;
            if (cnt_reg < res_lim_reg && bit_idx != 4'h0) begin
              trial_next[bit_idx - 4'h1] = 1'b1;
            end
          end
        end
        if (pulse_fall && cnt_reg == res_lim_reg + 4'h1) begin
          state_next = sarcs_pkg::SARCS_IDLE;
          busy_next = 1'b0;
          par_next = ~trial_reg;
          msb_inv_next = trial_reg[RES_BITS-1];
          ser_next = sarcs_pkg::SER_IDLE;
          sclk_next = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= sarcs_pkg::SARCS_IDLE;
      conv_d_reg <= 1'b0;
      ext_mode_reg <= 1'b0;
      ext_arm_reg <= 1'b0;
      phase_reg <= '0;
      cnt_reg <= sarcs_pkg::CNT_RESET;
      res_lim_reg <= sarcs_pkg::RES_LIM_12;
      trial_reg <= '0;
      par_reg <= sarcs_pkg::PAR_RESET;
      msb_inv_reg <= sarcs_pkg::MSB_INV_RESET;
      ser_reg <= sarcs_pkg::SER_IDLE;
      sclk_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      conv_d_reg <= conv_d_next;
      ext_mode_reg <= ext_mode_next;
      ext_arm_reg <= ext_arm_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      res_lim_reg <= res_lim_next;
      trial_reg <= trial_next;
      par_reg <= par_next;
      msb_inv_reg <= msb_inv_next;
      ser_reg <= ser_next;
      sclk_reg <= sclk_next;
      busy_reg <= busy_next;
    end
  end

  assign busy = busy_reg;
  assign par_data_n = par_reg;
  assign msb_inv = msb_inv_reg;
  assign ser_data = ser_reg;
  assign ser_clk = sclk_reg;
  assign dac_trial = trial_reg;

  // Checking helpers: width of each high phase of the driven clock
  logic [PH_W-1:0] hi_cnt_reg, hi_cnt_next;

  always_comb begin
    hi_cnt_next = sclk_reg ? hi_cnt_reg + PH_W'(1) : '0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hi_cnt_reg <= '0;
    end else begin
      hi_cnt_reg <= hi_cnt_next;
    end
  end

  // Checking helpers: length of each conversion in cycles
  logic [15:0] len_cnt_reg, len_cnt_next;

  always_comb begin
    len_cnt_next = busy_reg ? len_cnt_reg + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      len_cnt_reg <= 16'h0000;
    end else begin
      len_cnt_reg <= len_cnt_next;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_start_busy: assert property (
    (!busy_reg && conv_rise) |=> busy_reg && cnt_reg == 4'h0 && dac_trial == MSB_ONLY)
    else $error("Conversion did not start on convert edge");

  chk_ignore_cmd: assert property (
    (busy_reg && conv_rise) |=> $stable(res_lim_reg) && $stable(ext_mode_reg)
      && (cnt_reg == $past(cnt_reg) || cnt_reg == $past(cnt_reg) + 4'h1))
    else $error("Convert command disturbed running conversion");

  chk_busy_end: assert property (
    $fell(busy_reg) |-> $past(sclk_reg) && !sclk_reg && $past(cnt_reg) == res_lim_reg + 4'h1)
    else $error("Busy fell at the wrong pulse");

  chk_par_valid: assert property (
    $fell(busy_reg) |-> par_data_n == ~dac_trial ##1 $stable(par_data_n) [*2])
    else $error("Parallel result not the inverted decisions");

  chk_twos_bit: assert property (
    !busy_reg |-> msb_inv == ~par_data_n[RES_BITS-1])
    else $error("Twos complement bit not inverted MSB");

  chk_serial_bit: assert property (
    (pulse_rise && cnt_reg != 4'h0) |=> ser_data == ~$past(comp_s) && sclk_reg)
    else $error("Serial bit not the fresh decision");

  chk_serial_idle: assert property (
    !busy_reg |-> ser_data == sarcs_pkg::SER_IDLE && !ser_clk)
    else $error("Serial lines active outside conversion");

  chk_pulse_width: assert property (
    ($fell(sclk_reg) && !ext_mode_reg) |-> $past(hi_cnt_reg) == PH_W'(HALF_CYC - 1))
    else $error("Internal clock pulse width wrong");

  chk_msb_first: assert property (
    (busy_reg && pulse_rise && cnt_reg == 4'h1) |=> trial_reg[RES_BITS-2] == 1'b1)
    else $error("Second trial bit not raised after MSB");

  chk_conv_len: assert property (
    ($fell(busy_reg) && !ext_mode_reg) |-> len_cnt_reg == 16'((2 * res_lim_reg + 1) * HALF_CYC + 1))
    else $error("Conversion length wrong for resolution");

  chk_busy_hold: assert property (
    (busy_reg && cnt_reg <= res_lim_reg) |=> busy_reg)
    else $error("Busy dropped before final pulse");

  chk_short_bits: assert property (
    ($fell(busy_reg) && res_lim_reg == sarcs_pkg::RES_LIM_8) |-> dac_trial[RES_BITS-9:0] == '0)
    else $error("Bits below short resolution were decided");

  chk_ser_sync: assert property (
    $changed(ser_data) |-> $rose(sclk_reg) || $fell(busy_reg))
    else $error("Serial data changed off the driven clock");

  chk_no_restart: assert property (
    (busy_reg && $past(busy_reg) && $past(cnt_reg) != 4'h0) |-> cnt_reg != 4'h0)
    else $error("Running conversion restarted");

  chk_bit_limit: assert property (
    busy_reg |-> cnt_reg <= res_lim_reg + 4'h1)
    else $error("More pulses than selected resolution");

  chk_idle_state: assert property (
    !busy_reg |-> state_reg == sarcs_pkg::SARCS_IDLE && !sclk_reg)
    else $error("Sequencer not idle while busy low");

  cov_full_conv: cover property ($fell(busy_reg) && res_lim_reg == sarcs_pkg::RES_LIM_12);
  cov_short_conv: cover property ($fell(busy_reg) && res_lim_reg == sarcs_pkg::RES_LIM_8);
  cov_mid_conv: cover property ($fell(busy_reg) && res_lim_reg == sarcs_pkg::RES_LIM_10);
  cov_ignored_cmd: cover property (busy_reg && conv_rise);
  cov_ext_conv: cover property ($fell(busy_reg) && ext_mode_reg);
endmodule

// [dv/sarcs_far_end.sv]
// Far-side model: comparator on the trial word, serial and parallel capture
module sarcs_far_end (
  input wire logic clk_sys,
  input wire logic [11:0] vin,
  input wire logic [11:0] dac_trial,
  input wire logic busy,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic [11:0] par_data_n,
  output logic comp_pin,
  output logic [11:0] ser_word,
  output logic [11:0] par_word,
  output int ser_cnt,
  output int wid_min,
  output int wid_max
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_d = 1'b0;
  logic sclk_d = 1'b0;
  // Data seen while the clock was still high
  logic sdat_d = 1'b1;
  int pulses = 0;
  int wid = 0;
  assign comp_pin = (vin >= dac_trial);
  always @(posedge clk_sys) begin
    if (busy && !busy_d) begin
      ser_word = 12'h000;
      ser_cnt = 0;
      pulses = 0;
      wid_min = 9999;
      wid_max = 0;
    end
    if (!busy && busy_d) par_word = par_data_n;
    if (ser_clk && !sclk_d) begin
      pulses++;
      wid = 1;
    end else if (ser_clk) wid++;
    if (!ser_clk && sclk_d) begin
      if (wid < wid_min) wid_min = wid;
      if (wid > wid_max) wid_max = wid;
      // Pulse 1 carries no decision
      if (pulses > 1) begin
        ser_word = {ser_word[10:0], sdat_d};
        ser_cnt++;
      end
    end
    busy_d = busy;
    sclk_d = ser_clk;
    sdat_d = ser_data;
  end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the conversion sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 3;
  typedef struct {logic [11:0] v; logic [1:0] sel; logic [11:0] par; int bits;} sarcs_row_t;
  sarcs_row_t rows[6] = '{'{12'hA5C, 2'h0, 12'h5A3, 12}, '{12'h000, 2'h1, 12'hFFF, 10},
    '{12'hFFF, 2'h1, 12'h003, 10}, '{12'h800, 2'h2, 12'h7FF, 8}, '{12'h7FF, 2'h3, 12'h800, 12},
    '{12'h3C5, 2'h2, 12'hC3F, 8}};
  logic clk_sys = 0, rst = 1, convert_pin = 0, ext_clk_pin = 0, ext_clk_sel_pin = 0, ext_run = 0;
  logic [1:0] res_sel_pin = 2'h0;
  logic [11:0] vin = 12'h000;
  logic busy, msb_inv, ser_data, ser_clk, comp_pin;
  logic [11:0] par_data_n, dac_trial, ser_word, par_word;
  int ser_cnt, wid_min, wid_max, len, n, err_count = 0, compares = 0;
  sarcs_sequencer #(.HALF_CYC(H)) uut (.clk_sys(clk_sys), .rst(rst), .convert_pin(convert_pin),
    .ext_clk_pin(ext_clk_pin), .ext_clk_sel_pin(ext_clk_sel_pin), .comp_pin(comp_pin),
    .res_sel_pin(res_sel_pin), .busy(busy), .par_data_n(par_data_n), .msb_inv(msb_inv),
    .ser_data(ser_data), .ser_clk(ser_clk), .dac_trial(dac_trial));
  sarcs_far_end far (.clk_sys(clk_sys), .vin(vin), .dac_trial(dac_trial), .busy(busy), .ser_clk(ser_clk),
    .ser_data(ser_data), .par_data_n(par_data_n), .comp_pin(comp_pin), .ser_word(ser_word),
    .par_word(par_word), .ser_cnt(ser_cnt), .wid_min(wid_min), .wid_max(wid_max));
  always #4 clk_sys = ~clk_sys;
  // External converter clock runs only while ext_run is set
  always #62.5 ext_clk_pin = ext_run ? ~ext_clk_pin : 1'b0;
  task automatic conclude();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input logic [11:0] v, input logic [1:0] sel, input logic retrig);
    len = 0;
    vin = v;
    res_sel_pin = sel;
    convert_pin = 1'b1;
    for (n = 0; n < 10 && busy !== 1'b1; n++) @(negedge clk_sys);
    for (n = 0; n < 3000 && busy === 1'b1; n++) begin
      if (n == 4) convert_pin = 1'b0;
      if (retrig && n == 20) begin
        convert_pin = 1'b1;
        res_sel_pin = 2'h2;
      end
      if (n == 30) convert_pin = 1'b0;
      @(negedge clk_sys);
      len++;
    end
    if (n >= 3000 || len == 0) begin
      err_count++;
      $display("ERROR busy expected pulse seen none");
      conclude();
    end
    repeat (3) @(negedge clk_sys);
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    chk("busy", 12'h000, {11'h0, busy});
    chk("par_data_n", 12'hFFF, par_data_n);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    foreach (rows[i]) begin
      run(rows[i].v, rows[i].sel, 1'b0);
      chk("par_data_n", rows[i].par, par_word);
      chk("msb_inv", {11'h0, ~rows[i].par[11]}, {11'h0, msb_inv});
      chk("ser_word", rows[i].par >> (12 - rows[i].bits), ser_word);
      chk("ser_cnt", 12'(rows[i].bits), 12'(ser_cnt));
      chk("busy_len", 12'(1 + (2 * rows[i].bits + 1) * H), 12'(len));
      chk("wid_min", 12'(H), 12'(wid_min));
      chk("wid_max", 12'(H), 12'(wid_max));
      chk("ser_data", 12'h001, {11'h0, ser_data});
      $display("row %0d done", i);
    end
    run(12'h5A5, 2'h0, 1'b1);
    chk("par_data_n", 12'hA5A, par_word);
    chk("busy_len", 12'(1 + 25 * H), 12'(len));
    chk("ser_clk", 12'h000, {11'h0, ser_clk});
    $display("retrigger test done");
    ext_clk_sel_pin = 1'b1;
    ext_run = 1'b1;
    run(12'h123, 2'h0, 1'b0);
    ext_run = 1'b0;
    ext_clk_sel_pin = 1'b0;
    chk("par_data_n", 12'hEDC, par_word);
    chk("ser_cnt", 12'd12, 12'(ser_cnt));
    $display("external clock test done");
    convert_pin = 1'b1;
    repeat (20) @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    chk("busy", 12'h000, {11'h0, busy});
    chk("ser_clk", 12'h000, {11'h0, ser_clk});
    rst = 1'b0;
    convert_pin = 1'b0;
    $display("reset test done");
    conclude();
  end
endmodule
